// File: rtl/reply_fifo.sv
// Reply byte FIFO with registered full and empty flags
`timescale 1ns/10ps
module reply_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [CW-1:0]    next_count;
  logic             full;
  logic             empty;
  logic             push;
  logic             pop;
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr];
  assign next_count = count + CW'(push) - CW'(pop);
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
      full   <= 1'b0;
      empty  <= 1'b1;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= next_count;
      full  <= next_count == FULL_COUNT;
      in_ready <= next_count != FULL_COUNT;
      empty <= next_count == '0;
    end
  end
endmodule : reply_fifo

// File: rtl/serial_cfg_pkg.sv
// Package: register map, reset values, timing counts and framing types
package serial_cfg_pkg;
  localparam logic [11:0] RATE_OFS   = 12'h601;
  localparam logic [11:0] PARITY_OFS = 12'h602;
  localparam logic [11:0] STOP_OFS   = 12'h603;
  localparam logic [11:0] DELAY_OFS  = 12'h604;
  localparam logic [11:0] COMMIT_OFS = 12'h605;
  localparam logic [11:0] MODE_OFS   = 12'h608;
  localparam logic [15:0] RATE_RST   = 16'h2580;
  localparam logic [15:0] PARITY_RST = 16'h0000;
  localparam logic [15:0] STOP_RST   = 16'h0001;
  localparam logic [15:0] DELAY_RST  = 16'h0000;
  localparam logic [15:0] COMMIT_VAL = 16'h0001;
  localparam logic [15:0] MODE_RUN   = 16'h0001;
  localparam logic [15:0] MODE_BOOT  = 16'h0002;
  localparam logic [3:0]  CHAR_BITS  = 4'h8;
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          MS_NS         = 1000000;
  localparam int          MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
  localparam longint      CONFIRM_MIN   = 3;
  localparam longint      CONFIRM_CYCLES = CONFIRM_MIN * 60 * 1000000000 / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    B9600 = 3'h0, B19200 = 3'h1, B28800 = 3'h2, B38400 = 3'h3,
    B48000 = 3'h4, B57600 = 3'h5, B115200 = 3'h6, B230400 = 3'h7
  } baud_type;
  typedef struct packed {
    baud_type    baud;
    logic [1:0]  parity;
    logic        two_stop;
  } framing_type;
  localparam framing_type DEFAULT_FRAMING = '{baud: B9600, parity: 2'h0, two_stop: 1'b0};
  // Returns {valid, baud code} for a line rate register value
  function automatic logic [3:0] decode_rate(input logic [15:0] v);
    unique case (v)
      16'h2580: decode_rate = {1'b1, B9600};
      16'h4B00: decode_rate = {1'b1, B19200};
      16'h7080: decode_rate = {1'b1, B28800};
      16'h9600: decode_rate = {1'b1, B38400};
      16'hBB80: decode_rate = {1'b1, B48000};
      16'hE100: decode_rate = {1'b1, B57600};
      16'h0073: decode_rate = {1'b1, B115200};
      16'h00E6: decode_rate = {1'b1, B230400};
      default:  decode_rate = 4'h0;
    endcase
  endfunction : decode_rate
endpackage : serial_cfg_pkg

// File: rtl/serial_link_config_commit.sv
// Serial framing configuration with commit, confirmation window and failsafe address
// How it works
// (RQ1) After reset the port runs 9600 baud, no parity, 8 data bits, 1 stop.
// (RQ2) Only the eight listed baud rates are accepted.
// (RQ3) Rates under 115200 are literal; higher rates use their first three digits.
// (RQ4) Parity value 0 none, 1 odd, 2 even.
// (RQ5) Stop value 1 gives one stop bit, 2 gives two.
// (RQ6) Replies wait at least the programmed milliseconds; zero means no wait.
// (RQ7) Writing 1 to the commit register applies all staged settings at once.
// (RQ8) Commit opens a 3-minute window; a good query makes settings permanent.
// (RQ9) Any successfully received query counts as confirmation.
// (RQ10) Window expiry or reboot before confirmation restores previous settings; reset here loads the default framing instead of the previous one.
// Expiry here restores the previous framing only; the reply delay of the expired commit stays in use.
// (RQ11) Switch address 0 forces default framing regardless of stored settings.
// (RQ12) Switch address 0 makes the device answer every slave address.
// (RQ13) At switch 0 new settings are unused and cannot be confirmed; a commit at switch 0 here still puts the new reply delay in use at once.
// (RQ14) Switch 0 at power-on enters bootloader mode; settings stay changeable.
// (RQ15) Master must reboot with non-zero switch to read data registers.
// (RQ16) Master writes settings, commits, switches framing, then reads within 3 minutes.
// (RQ17) Master uses default framing towards a device at switch 0.
// (RQ18) Other slaves should leave the line while a device sits at 0.
// (RQ19) A reply delay of 0 to 100 ms is normally enough.
// (RQ20) Character length is always eight data bits.
// (RQ21) A commit with any unsupported value leaves the active framing unchanged.
`timescale 1ns/10ps
module serial_link_config_commit #(
  parameter int     MS_CYCLES      = serial_cfg_pkg::MS_CYCLES,
  parameter longint CONFIRM_CYCLES = serial_cfg_pkg::CONFIRM_CYCLES,
  parameter int     WIDTH          = 8,
  parameter int     DEPTH          = 8
) (
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [11:0]                 reg_addr,
  input  wire logic [15:0]                 reg_wdata,
  output logic      [15:0]                 reg_rdata,
  input  wire logic                        query_ok,
  input  wire logic [3:0]                  switch_addr,
  output serial_cfg_pkg::framing_type      framing,
  output logic      [3:0]                  char_bits,
  output logic                             accept_any,
  output logic                             boot_mode,
  output logic                             trial_pending,
  input  wire logic                        reply_valid,
  output logic                             reply_ready,
  input  wire logic [WIDTH-1:0]            reply_data,
  output logic                             tx_valid,
  input  wire logic                        tx_ready,
  output logic      [WIDTH-1:0]            tx_data
);
  typedef enum logic [1:0] {IDLE = 2'b00, WAIT = 2'b01, SEND = 2'b10} reply_state_type;
  logic [15:0]                 rate;
  logic [15:0]                 parity;
  logic [15:0]                 stop;
  logic [15:0]                 delay_ms;
  logic [15:0]                 act_delay;
  serial_cfg_pkg::framing_type trial;
  serial_cfg_pkg::framing_type perm;
  logic [63:0]                 window_cnt;
  logic [3:0]                  sw_s1;
  logic [3:0]                  sw_s2;
  logic [3:0]                  sw_s3;
  logic [3:0]                  sw_addr;
  logic [1:0]                  start_cnt;
  logic                        sw_zero;
  logic [3:0]                  rate_dec;
  logic                        commit;
  logic                        commit_ok;
  logic                        expire;
  reply_state_type             state;
  logic [31:0]                 ms_cnt;
  logic [15:0]                 ms_left;
  logic                        f_valid;
  logic                        f_ready;
  logic [WIDTH-1:0]            f_data;
  logic [47:0]                 wait_need;
  logic [47:0]                 wait_cyc;

  ////////////////////////////////////////////////////////////////////////////////
  // Switch synchroniser and power-on bootloader capture
  always_ff @(posedge clock) begin
    sw_s1 <= switch_addr;
    sw_s2 <= sw_s1;
    sw_s3 <= sw_s2;
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sw_addr <= 4'h1;
    end else if (sw_s2 == sw_s3) begin
      sw_addr <= sw_s3;
    end
  end
  assign sw_zero = sw_addr == 4'h0;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      start_cnt <= 2'h0;
      boot_mode <= 1'b0;
    end else if (start_cnt != 2'h3) begin
      start_cnt <= start_cnt + 2'h1;
      if (start_cnt == 2'h2) begin
        boot_mode <= (sw_s2 == 4'h0) && (sw_s3 == 4'h0); // RQ14
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Staged registers and read port
  assign rate_dec  = serial_cfg_pkg::decode_rate(rate); // RQ2 RQ3
  assign commit    = reg_wr && reg_addr == serial_cfg_pkg::COMMIT_OFS && reg_wdata == serial_cfg_pkg::COMMIT_VAL;
  assign commit_ok = commit && rate_dec[3] && parity < 16'h0003
                     && (stop == 16'h0001 || stop == 16'h0002); // RQ21
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rate     <= serial_cfg_pkg::RATE_RST;
      parity   <= serial_cfg_pkg::PARITY_RST;
      stop     <= serial_cfg_pkg::STOP_RST;
      delay_ms <= serial_cfg_pkg::DELAY_RST;
    end else if (reg_wr) begin
      unique case (reg_addr)
        serial_cfg_pkg::RATE_OFS:   rate     <= reg_wdata;
        serial_cfg_pkg::PARITY_OFS: parity   <= reg_wdata;
        serial_cfg_pkg::STOP_OFS:   stop     <= reg_wdata;
        serial_cfg_pkg::DELAY_OFS:  delay_ms <= reg_wdata;
        default: ;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        serial_cfg_pkg::RATE_OFS:   reg_rdata <= rate;
        serial_cfg_pkg::PARITY_OFS: reg_rdata <= parity;
        serial_cfg_pkg::STOP_OFS:   reg_rdata <= stop;
        serial_cfg_pkg::DELAY_OFS:  reg_rdata <= delay_ms;
        serial_cfg_pkg::MODE_OFS:   reg_rdata <= boot_mode ? serial_cfg_pkg::MODE_BOOT : serial_cfg_pkg::MODE_RUN;
        default:                    reg_rdata <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Commit, confirmation window and revert
  assign expire = trial_pending && !sw_zero && window_cnt == 64'(CONFIRM_CYCLES - 1);
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      trial         <= serial_cfg_pkg::DEFAULT_FRAMING; // RQ1 RQ10
      perm          <= serial_cfg_pkg::DEFAULT_FRAMING;
      act_delay     <= serial_cfg_pkg::DELAY_RST;
      trial_pending <= 1'b0;
      window_cnt    <= 64'h0;
    end else if (commit_ok) begin
      trial.baud     <= serial_cfg_pkg::baud_type'(rate_dec[2:0]); // RQ7
      trial.parity   <= parity[1:0]; // RQ4
      trial.two_stop <= stop == 16'h0002; // RQ5
      act_delay      <= delay_ms;
      trial_pending  <= 1'b1;
      window_cnt     <= 64'h0;
    end else if (trial_pending && !sw_zero && !commit) begin // RQ13
      if (query_ok) begin
        perm          <= trial; // RQ8 RQ9
        trial_pending <= 1'b0;
      end else if (expire) begin
        trial         <= perm; // RQ10
        trial_pending <= 1'b0;
      end else begin
        window_cnt <= window_cnt + 64'h1;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      framing    <= serial_cfg_pkg::DEFAULT_FRAMING;
      accept_any <= 1'b0;
      char_bits  <= serial_cfg_pkg::CHAR_BITS;
    end else begin
      framing    <= sw_zero ? serial_cfg_pkg::DEFAULT_FRAMING : (trial_pending ? trial : perm); // RQ11 RQ13
      accept_any <= sw_zero; // RQ12
      char_bits  <= serial_cfg_pkg::CHAR_BITS; // RQ20
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reply delay and output stage
  reply_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rst_n     (rst_n),
    .in_valid  (reply_valid),
    .in_ready  (reply_ready),
    .in_data   (reply_data),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );
  assign f_ready = state == SEND && (!tx_valid || tx_ready);
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state   <= IDLE;
      ms_cnt  <= 32'h0;
      ms_left <= 16'h0;
    end else begin
      unique case (state)
        IDLE: begin
          if (f_valid) begin
            ms_left <= act_delay;
            ms_cnt  <= 32'h0;
            state   <= (act_delay == 16'h0) ? SEND : WAIT; // RQ6
          end
        end
        WAIT: begin
          if (ms_cnt == 32'(MS_CYCLES - 1)) begin
            ms_cnt  <= 32'h0;
            ms_left <= ms_left - 16'h1;
            if (ms_left == 16'h1) begin
              state <= SEND; // RQ6
            end
          end else begin
            ms_cnt <= ms_cnt + 32'h1;
          end
        end
        SEND: begin
          if (!f_valid && !tx_valid) begin
            state <= IDLE;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tx_valid <= 1'b0;
      tx_data  <= '0;
    end else if (f_ready) begin
      tx_valid <= f_valid;
      tx_data  <= f_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  // Cycles spent waiting against the delay latched when the burst started
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wait_need <= 48'h0;
      wait_cyc  <= 48'h0;
    end else if (state == IDLE) begin
      wait_need <= 48'(act_delay) * 48'(MS_CYCLES);
      wait_cyc  <= 48'h0;
    end else if (state == WAIT) begin
      wait_cyc <= wait_cyc + 48'h1;
    end
  end
  sequence wait_done_s;
    state == WAIT ##1 state == SEND;
  endsequence
  sequence bad_commit_s;
    commit && !commit_ok;
  endsequence
  sequence zero_sw_s;
    sw_zero;
  endsequence
  fail_commit_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ21
    bad_commit_s |=> $stable(trial) && $stable(perm)) else $error("bad commit changed framing");
  zero_frame_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ11
    zero_sw_s |=> framing == serial_cfg_pkg::DEFAULT_FRAMING) else $error("switch zero framing not default");
  any_addr_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ12
    zero_sw_s |=> accept_any) else $error("switch zero not answering all");
  no_confirm_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ13
    trial_pending && sw_zero && !commit |=> trial_pending && $stable(perm)) else $error("confirmed at switch zero");
  confirm_perm_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ8
    trial_pending && !sw_zero && query_ok && !commit |=> !trial_pending && perm == $past(trial))
    else $error("query did not confirm");
  expire_rev_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ10
    expire && !query_ok && !commit |=> !trial_pending && trial == perm) else $error("expiry did not revert");
  commit_apply_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ7
    commit_ok ##1 !sw_zero && !commit ##1 !sw_zero |-> framing == $past(trial)) else $error("commit not applied");
  char_len_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ20
    char_bits == serial_cfg_pkg::CHAR_BITS) else $error("char length changed");
  reply_wait_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ6
    state == WAIT |-> !f_ready) else $error("reply sent before delay");
  delay_len_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ6
    wait_done_s |-> wait_cyc >= wait_need) else $error("reply delay too short");
  window_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ13
    trial_pending && sw_zero && !commit |=> $stable(window_cnt)) else $error("window ran at switch zero");
  boot_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // RQ14
    start_cnt == 2'h3 |=> $stable(boot_mode)) else $error("boot mode changed after power-on");
endmodule : serial_link_config_commit

// File: test/modbus_master_model.sv
// Far-side master: consumes reply bytes promptly, slowly or not at all
`timescale 1ns/10ps
module modbus_master_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [1:0] mode,
  output logic            tx_ready
);
  logic [1:0] phase = 2'h0;
  initial tx_ready = 1'b0;
  // Mode 0 prompt, 1 one cycle in four, 2 stalled
  always @(negedge clock) begin
    phase <= phase + 2'h1;
    tx_ready <= rst_n && (mode == 2'h0 || (mode == 2'h1 && phase == 2'h0));
  end
endmodule : modbus_master_model

// File: test/test_serial_link_config_commit.sv
// Self-checking bench for the serial configuration block
`timescale 1ns/10ps
module test_serial_link_config_commit;
  logic clock = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, query_ok = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [3:0] switch_addr = 4'h1, char_bits;
  serial_cfg_pkg::framing_type framing;
  logic accept_any, boot_mode, trial_pending, reply_valid = 1'b0, reply_ready, tx_valid, tx_ready, rd_d = 1'b0;
  logic [7:0] reply_data = 8'h00, tx_data, lfsr = 8'h4F;
  logic [1:0] mode = 2'h0;
  logic [15:0] rq[$], prev, fexp;
  logic [7:0] txq[$];
  logic [15:0] rates[8] = '{16'h2580, 16'h4B00, 16'h7080, 16'h9600, 16'hBB80, 16'hE100, 16'h0073, 16'h00E6};
  int errors = 0, comparisons = 0, taken, cnt;
  always #2 clock = ~clock;
  serial_link_config_commit #(.MS_CYCLES(4), .CONFIRM_CYCLES(50), .WIDTH(8), .DEPTH(8)) serial_link_config_commit_i (
    .clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .query_ok(query_ok), .switch_addr(switch_addr), .framing(framing),
    .char_bits(char_bits), .accept_any(accept_any), .boot_mode(boot_mode), .trial_pending(trial_pending),
    .reply_valid(reply_valid), .reply_ready(reply_ready), .reply_data(reply_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data));
  modbus_master_model modbus_master_model_i (.clock(clock), .rst_n(rst_n), .mode(mode), .tx_ready(tx_ready));
  ////////////////////////////////////////////////////////////////////////////////
  function logic [7:0] next_rand();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : next_rand
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(negedge clock); reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
    @(negedge clock); reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [15:0] exp);
    @(negedge clock); reg_rd = 1'b1; reg_addr = a; rq.push_back(exp);
    @(negedge clock); reg_rd = 1'b0;
  endtask : rd
  task automatic cfg(input logic [15:0] r, input logic [15:0] p, input logic [15:0] s, input logic [15:0] d);
    wr(serial_cfg_pkg::RATE_OFS, r); wr(serial_cfg_pkg::PARITY_OFS, p);
    wr(serial_cfg_pkg::STOP_OFS, s); wr(serial_cfg_pkg::DELAY_OFS, d);
    wr(serial_cfg_pkg::COMMIT_OFS, serial_cfg_pkg::COMMIT_VAL);
    repeat (3) @(negedge clock);
  endtask : cfg
  task automatic query();
    @(negedge clock); query_ok = 1'b1;
    @(negedge clock); query_ok = 1'b0;
    repeat (2) @(negedge clock);
  endtask : query
  task automatic rst(input logic [3:0] sw);
    @(negedge clock); rst_n = 1'b0; switch_addr = sw;
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    repeat (6) @(negedge clock);
  endtask : rst
  task automatic fill(input int n, output int got);
    got = 0;
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      if (reply_ready !== 1'b1) break;
      reply_valid = 1'b1; reply_data = next_rand(); txq.push_back(reply_data); got++;
    end
    @(negedge clock); reply_valid = 1'b0;
  endtask : fill
  task automatic wait_tx();
    cnt = 0;
    while (tx_valid !== 1'b1 && cnt < 100) begin @(negedge clock); cnt++; end
    repeat (4) @(negedge clock);
  endtask : wait_tx
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (rd_d) check(reg_rdata, rq.pop_front());
    if (tx_valid === 1'b1 && tx_ready === 1'b1) check({8'h00, tx_data}, {8'h00, txq.pop_front()});
    rd_d <= reg_rd;
  end
  initial begin #(4 * 20000); errors++; conclude(); end
  initial begin
    rst(4'h1);
    rd(serial_cfg_pkg::RATE_OFS, serial_cfg_pkg::RATE_RST);
    rd(serial_cfg_pkg::PARITY_OFS, serial_cfg_pkg::PARITY_RST);
    rd(serial_cfg_pkg::STOP_OFS, serial_cfg_pkg::STOP_RST);
    rd(serial_cfg_pkg::DELAY_OFS, serial_cfg_pkg::DELAY_RST);
    rd(serial_cfg_pkg::MODE_OFS, serial_cfg_pkg::MODE_RUN);
    wr(12'h606, 16'hFFFF);
    rd(12'h606, 16'h0000);
    check(16'(framing), 16'(serial_cfg_pkg::DEFAULT_FRAMING));
    check(16'(char_bits), 16'h0008);
    $display("test reset values done");
    prev = 16'(serial_cfg_pkg::DEFAULT_FRAMING);
    for (int i = 0; i < 8; i++) begin
      wr(serial_cfg_pkg::RATE_OFS, rates[i]); wr(serial_cfg_pkg::PARITY_OFS, 16'(i % 3));
      check(16'(framing), prev);
      cfg(rates[i], 16'(i % 3), 16'((i % 2) + 1), 16'h0000);
      fexp = {10'h000, 3'(i), 2'(i % 3), i % 2 == 1};
      check(16'(framing), fexp);
      check(16'(trial_pending), 16'h0001);
      check(16'(char_bits), 16'h0008);
      rd(serial_cfg_pkg::RATE_OFS, rates[i]);
      query();
      check(16'(trial_pending), 16'h0000);
      prev = fexp;
    end
    $display("test rate parity stop table done");
    for (int k = 0; k < 3; k++) begin
      cfg(k == 0 ? 16'h1234 : rates[0], k == 1 ? 16'h0003 : 16'h0000, k == 2 ? 16'h0003 : 16'h0001, 16'h0000);
      check(16'(framing), prev);
      check(16'(trial_pending), 16'h0000);
    end
    $display("test unsupported values done");
    cfg(rates[1], 16'h0000, 16'h0001, 16'h0000);
    repeat (36) @(negedge clock);
    check(16'(trial_pending), 16'h0001);
    check(16'(framing), 16'h0008);
    repeat (30) @(negedge clock);
    check(16'(framing), prev);
    check(16'(trial_pending), 16'h0000);
    $display("test window expiry done");
    switch_addr = 4'h0;
    repeat (6) @(negedge clock);
    check(16'(accept_any), 16'h0001);
    check(16'(framing), 16'(serial_cfg_pkg::DEFAULT_FRAMING));
    cfg(rates[2], 16'h0002, 16'h0002, 16'h0000);
    repeat (60) @(negedge clock);
    query();
    check(16'(trial_pending), 16'h0001);
    check(16'(framing), 16'(serial_cfg_pkg::DEFAULT_FRAMING));
    switch_addr = 4'h3;
    repeat (6) @(negedge clock);
    check(16'(accept_any), 16'h0000);
    check(16'(framing), 16'h0015);
    query();
    check(16'(trial_pending), 16'h0000);
    $display("test failsafe address done");
    cfg(rates[0], 16'h0000, 16'h0001, 16'h0002);
    query();
    fill(1, taken);
    wait_tx();
    check(16'(cnt >= 8 && cnt < 100), 16'h0001);
    cfg(rates[0], 16'h0000, 16'h0001, 16'h0000);
    query();
    fill(1, taken);
    wait_tx();
    check(16'(cnt <= 4), 16'h0001);
    mode = 2'h2;
    fill(20, taken);
    check(16'(taken >= 8), 16'h0001);
    check(16'(reply_ready), 16'h0000);
    mode = 2'h1;
    cnt = 0;
    while (txq.size() != 0 && cnt < 400) begin @(negedge clock); cnt++; end
    mode = 2'h0;
    check(16'(txq.size()), 16'h0000);
    $display("test reply stream done");
    cfg(rates[5], 16'h0001, 16'h0001, 16'h0000);
    rst(4'h1);
    check(16'(framing), 16'(serial_cfg_pkg::DEFAULT_FRAMING));
    check(16'(trial_pending), 16'h0000);
    rst(4'h0);
    check(16'(framing), 16'(serial_cfg_pkg::DEFAULT_FRAMING));
    check(16'(boot_mode), 16'h0001);
    rd(serial_cfg_pkg::MODE_OFS, serial_cfg_pkg::MODE_BOOT);
    wr(serial_cfg_pkg::PARITY_OFS, 16'h0001);
    rd(serial_cfg_pkg::PARITY_OFS, 16'h0001);
    rst(4'h2);
    check(16'(boot_mode), 16'h0000);
    repeat (2) @(negedge clock);
    $display("test boot mode done");
    conclude();
  end
endmodule : test_serial_link_config_commit
